// File: rcs_cam_model.sv
// Camera and decoder model answering the sequencer's capture and decode handshakes.
module rcs_cam_model
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Bench control
  input logic clr,
  input logic slow,
  input logic stall,
  input logic [7:0] good_at,
  output logic [7:0] cap_cnt,
  // Sequencer side
  input logic capture_req,
  input logic decode_run,
  input logic decode_abort,
  output logic capture_done,
  output logic decode_good,
  output logic decode_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wait_q;
  logic [7:0] dec_q;

  always @(posedge aclk)
  begin
    capture_done <= 1'b0;
    decode_good <= 1'b0;
    decode_fail <= 1'b0;
    if (!aresetn || clr || decode_abort)
    begin
      wait_q <= 8'h00;
      dec_q <= 8'h00;
      if (!aresetn || clr)
        cap_cnt <= 8'h00;
    end
    else
    begin
      if (capture_req && !capture_done)
      begin
        wait_q <= wait_q + 8'h01;
        if (wait_q == 8'h02)
        begin
          capture_done <= 1'b1;
          cap_cnt <= cap_cnt + 8'h01;
          wait_q <= 8'h00;
        end
      end
      // A stalled decoder never answers, so only an abort, clr or reset ends its work.
      if (decode_run && !decode_good && !decode_fail && !stall)
      begin
        dec_q <= dec_q + 8'h01;
        if (dec_q == (slow ? 8'h28 : 8'h02))
        begin
          dec_q <= 8'h00;
          decode_good <= (cap_cnt == good_at);
          decode_fail <= (cap_cnt != good_at);
        end
      end
    end
  end
endmodule // rcs_cam_model

// File: rcs_defines.vh
// Constants for the read cycle sequencer.
`ifndef RCS_DEFINES_VH
`define RCS_DEFINES_VH
`define RCS_CYC_PER_MS 32'h0001_86A0
`define RCS_TRIG_DLY_RST 16'h0000
`define RCS_ITER_GAP_RST 16'h002D
`define RCS_CYCLE_LIM_RST 16'h07D0
`define RCS_TOOL_LIM_RST 16'h01F4
`define RCS_ITER_RST 8'h01
`define RCS_NCAP_RST 8'h01
`define RCS_CTRL_RST 8'h05
`define RCS_ADDR_CTRL 6'h00
`define RCS_ADDR_ITER 6'h04
`define RCS_ADDR_DLY 6'h08
`define RCS_ADDR_GAP 6'h0C
`define RCS_ADDR_CYC 6'h10
`define RCS_ADDR_TOOL 6'h14
`define RCS_ADDR_STAT 6'h18
`define RCS_ADDR_IRQ 6'h1C
`define RCS_ADDR_MASK 6'h20
`define RCS_ADDR_SWT 6'h24
`define RCS_CTRL_DONE 0
`define RCS_CTRL_NEWTRIG 1
`define RCS_CTRL_FIXED 2
`define RCS_CTRL_TRIGCAP 3
`define RCS_CTRL_PROTO 4
`define RCS_RESP_OKAY 2'b00
`define RCS_RESP_SLVERR 2'b10
`define RCS_IRQ_W 4
`endif

// File: rcs_ms_timer.v
// Millisecond down counter used for the delay and time limits.
`include "rcs_defines.vh"
module rcs_ms_timer
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire start,
  input wire stop,
  input wire ms_tick,
  input wire [15:0] limit_ms,
  // Status
  output reg running,
  output reg expired
);
  reg [15:0] left_q;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      left_q <= 16'h0000;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else
    begin
      expired <= 1'b0;
      if (stop)
      begin
        running <= 1'b0;
      end
      else if (start)
      begin
        if (limit_ms == 16'h0000)
        begin
          expired <= 1'b1;
          running <= 1'b0;
        end
        else
        begin
          left_q <= limit_ms;
          running <= 1'b1;
        end
      end
      else if (running && ms_tick)
      begin
        if (left_q == 16'h0001)
        begin
          running <= 1'b0;
          expired <= 1'b1;
        end
        left_q <= left_q - 16'h0001;
      end
    end
  end
endmodule // rcs_ms_timer

// File: rcs_read_cycle.v
// Read cycle sequencer with AXI4-Lite registers.
//
// Summary of operation
// - A start trigger opens a cycle that captures images and attempts decoding.
// - Cycle ends on a good read or when images run out failing.
// - After a cycle ends, only a fresh trigger starts the next.
// - The dedicated trigger pin starts a read cycle.
// - A received serial or socket start string starts a read cycle.
// - With the controller protocol active, a controller command starts a cycle.
// - Acquisition waits a programmable millisecond delay after trigger, default zero.
// - With one iteration, each capture is taken once, else failure.
// - Above one iteration, passes repeat until found or maximum passes reached.
// - Timed mode inserts a millisecond gap between passes, default 45.
// - Captures within a pass follow back to back with no gap.
// - Triggered capture mode starts each later pass on another trigger.
// - Optional fixed cycle time limit in milliseconds, default 2000.
// - With new-trigger ending, a trigger during a cycle fails it, except while waiting for a pass trigger or holding a result.
// - Fixed time runs from trigger; it stops work and holds early results.
// - Each decoder is stopped after a per-tool time limit, default 500.
// - Pass, fail and complete outputs update at every cycle end.
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`include "rcs_defines.vh"
module rcs_read_cycle
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite slave
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Start sources
  input wire trigger_pin,
  input wire serial_start,
  input wire plc_start,
  // Capture and decoder handshake
  output reg capture_req,
  input wire capture_done,
  output reg decode_run,
  input wire decode_good,
  input wire decode_fail,
  output reg decode_abort,
  // Result outputs
  output reg cycle_pass,
  output reg cycle_fail,
  output reg cycle_complete,
  output reg irq
);
  localparam S_IDLE = 7'b000_0001;
  localparam S_DELAY = 7'b000_0010;
  localparam S_CAP = 7'b000_0100;
  localparam S_DEC = 7'b000_1000;
  localparam S_GAP = 7'b001_0000;
  localparam S_WTRIG = 7'b010_0000;
  localparam S_HOLD = 7'b100_0000;
  reg [6:0] state_q;
  reg [7:0] ctrl_q;
  reg [7:0] iter_max_q;
  reg [7:0] ncap_q;
  reg [15:0] dly_q;
  reg [15:0] gap_q;
  reg [15:0] cyc_q;
  reg [15:0] tool_q;
  reg [3:0] irq_stat_q;
  reg [3:0] irq_mask_q;
  reg sw_trig_q;
  reg [7:0] iter_q;
  reg [7:0] cap_q;
  reg result_q;
  reg [31:0] div_q;
  reg ms_tick;
  reg trig_s1_q;
  reg trig_s2_q;
  reg trig_s3_q;
  reg ser_s1_q;
  reg ser_s2_q;
  reg ser_s3_q;
  reg plc_s1_q;
  reg plc_s2_q;
  reg plc_s3_q;
  reg t_dly_start;
  reg t_gap_start;
  reg t_cyc_start;
  reg t_tool_start;
  reg t_stop;
  reg t_tool_stop;
  wire dly_run;
  wire dly_exp;
  wire gap_run;
  wire gap_exp;
  wire cyc_run;
  wire cyc_exp;
  wire tool_run;
  wire tool_exp;
  reg aw_hold_q;
  reg w_hold_q;
  reg [5:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire pin_edge;
  wire ser_edge;
  wire plc_edge;
  wire start_evt;
  wire wr_go;
  wire end_evt;
  reg [3:0] irq_set;
  // Synchronise and edge-detect every external start source.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      trig_s3_q <= 1'b0;
      ser_s1_q <= 1'b0;
      ser_s2_q <= 1'b0;
      ser_s3_q <= 1'b0;
      plc_s1_q <= 1'b0;
      plc_s2_q <= 1'b0;
      plc_s3_q <= 1'b0;
    end
    else
    begin
      trig_s1_q <= trigger_pin;
      trig_s2_q <= trig_s1_q;
      trig_s3_q <= trig_s2_q;
      ser_s1_q <= serial_start;
      ser_s2_q <= ser_s1_q;
      ser_s3_q <= ser_s2_q;
      plc_s1_q <= plc_start;
      plc_s2_q <= plc_s1_q;
      plc_s3_q <= plc_s2_q;
    end
  end
  assign pin_edge = trig_s2_q & ~trig_s3_q;
  assign ser_edge = ser_s2_q & ~ser_s3_q;
  assign plc_edge = plc_s2_q & ~plc_s3_q & ctrl_q[`RCS_CTRL_PROTO];
  assign start_evt = pin_edge | ser_edge | plc_edge | sw_trig_q;
  // Millisecond enable pulse.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= 32'h0000_0000;
      ms_tick <= 1'b0;
    end
    else
    begin
      ms_tick <= (div_q == `RCS_CYC_PER_MS - 32'h0000_0001);
      if (div_q == `RCS_CYC_PER_MS - 32'h0000_0001)
        div_q <= 32'h0000_0000;
      else
        div_q <= div_q + 32'h0000_0001;
    end
  end
  rcs_ms_timer u_dly (.aclk(aclk), .aresetn(aresetn), .start(t_dly_start), .stop(t_stop),
    .ms_tick(ms_tick), .limit_ms(dly_q), .running(dly_run), .expired(dly_exp));
  rcs_ms_timer u_gap (.aclk(aclk), .aresetn(aresetn), .start(t_gap_start), .stop(t_stop),
    .ms_tick(ms_tick), .limit_ms(gap_q), .running(gap_run), .expired(gap_exp));
  rcs_ms_timer u_cyc (.aclk(aclk), .aresetn(aresetn), .start(t_cyc_start), .stop(1'b0),
    .ms_tick(ms_tick), .limit_ms(cyc_q), .running(cyc_run), .expired(cyc_exp));
  rcs_ms_timer u_tool (.aclk(aclk), .aresetn(aresetn), .start(t_tool_start),
    .stop(t_tool_stop), .ms_tick(ms_tick), .limit_ms(tool_q), .running(tool_run),
    .expired(tool_exp));
  // Fixed-time expiry ends the cycle only when that end condition is enabled.
  assign end_evt = ctrl_q[`RCS_CTRL_FIXED] & cyc_exp & (state_q != S_IDLE);
  // Sequencer.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q <= S_IDLE;
      iter_q <= 8'h00;
      cap_q <= 8'h00;
      result_q <= 1'b0;
      capture_req <= 1'b0;
      decode_run <= 1'b0;
      decode_abort <= 1'b0;
      cycle_pass <= 1'b0;
      cycle_fail <= 1'b0;
      cycle_complete <= 1'b0;
      t_dly_start <= 1'b0;
      t_gap_start <= 1'b0;
      t_cyc_start <= 1'b0;
      t_tool_start <= 1'b0;
      t_stop <= 1'b0;
      t_tool_stop <= 1'b0;
      irq_set <= 4'h0;
    end
    else
    begin
      t_dly_start <= 1'b0;
      t_gap_start <= 1'b0;
      t_cyc_start <= 1'b0;
      t_tool_start <= 1'b0;
      t_stop <= 1'b0;
      t_tool_stop <= 1'b0;
      decode_abort <= 1'b0;
      irq_set <= 4'h0;
      if (end_evt)
      begin
        state_q <= S_IDLE;
        capture_req <= 1'b0;
        decode_run <= 1'b0;
        decode_abort <= decode_run;
        t_stop <= 1'b1;
        t_tool_stop <= 1'b1;
        cycle_pass <= result_q;
        cycle_fail <= ~result_q;
        cycle_complete <= 1'b1;
        irq_set <= {1'b0, 1'b1, ~result_q, result_q};
      end
      else if (start_evt && ctrl_q[`RCS_CTRL_NEWTRIG] && state_q != S_IDLE
        && !(state_q == S_WTRIG) && !(state_q == S_HOLD))
      begin
        state_q <= S_IDLE;
        capture_req <= 1'b0;
        decode_run <= 1'b0;
        decode_abort <= decode_run;
        t_stop <= 1'b1;
        t_tool_stop <= 1'b1;
        cycle_pass <= 1'b0;
        cycle_fail <= 1'b1;
        cycle_complete <= 1'b1;
        irq_set <= 4'b1110;
      end
      else
      begin
        case (state_q)
          S_IDLE:
          begin
            if (start_evt)
            begin
              cycle_pass <= 1'b0;
              cycle_fail <= 1'b0;
              cycle_complete <= 1'b0;
              result_q <= 1'b0;
              iter_q <= 8'h00;
              cap_q <= 8'h00;
              t_dly_start <= 1'b1;
              t_cyc_start <= 1'b1;
              state_q <= S_DELAY;
            end
          end
          S_DELAY:
          begin
            if (dly_exp)
            begin
              capture_req <= 1'b1;
              state_q <= S_CAP;
            end
          end
          S_CAP:
          begin
            if (capture_done)
            begin
              capture_req <= 1'b0;
              decode_run <= 1'b1;
              t_tool_start <= 1'b1;
              state_q <= S_DEC;
            end
          end
          S_DEC:
          begin
            if (decode_good || decode_fail || tool_exp)
            begin
              decode_run <= 1'b0;
              t_tool_stop <= 1'b1;
              decode_abort <= tool_exp & ~decode_good & ~decode_fail;
              if (decode_good)
              begin
                result_q <= 1'b1;
                state_q <= S_HOLD;
              end
              else if (cap_q + 8'h01 < ncap_q)
              begin
                cap_q <= cap_q + 8'h01;
                capture_req <= 1'b1;
                state_q <= S_CAP;
              end
              else if (iter_q + 8'h01 < iter_max_q)
              begin
                iter_q <= iter_q + 8'h01;
                cap_q <= 8'h00;
                if (ctrl_q[`RCS_CTRL_TRIGCAP])
                  state_q <= S_WTRIG;
                else
                begin
                  t_gap_start <= 1'b1;
                  state_q <= S_GAP;
                end
              end
              else
              begin
                result_q <= 1'b0;
                state_q <= S_HOLD;
              end
            end
          end
          S_GAP:
          begin
            if (gap_exp)
            begin
              capture_req <= 1'b1;
              state_q <= S_CAP;
            end
          end
          S_WTRIG:
          begin
            if (start_evt)
            begin
              capture_req <= 1'b1;
              state_q <= S_CAP;
            end
          end
          S_HOLD:
          begin
            if (!(ctrl_q[`RCS_CTRL_FIXED] && cyc_run))
            begin
              state_q <= S_IDLE;
              cycle_pass <= result_q;
              cycle_fail <= ~result_q;
              cycle_complete <= 1'b1;
              irq_set <= {1'b0, 1'b1, ~result_q, result_q};
            end
          end
          default:
          begin
            state_q <= S_IDLE;
          end
        endcase
      end
    end
  end
  // AXI4-Lite write path.
  assign wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCS_RESP_OKAY;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 6'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= `RCS_CTRL_RST;
      iter_max_q <= `RCS_ITER_RST;
      ncap_q <= `RCS_NCAP_RST;
      dly_q <= `RCS_TRIG_DLY_RST;
      gap_q <= `RCS_ITER_GAP_RST;
      cyc_q <= `RCS_CYCLE_LIM_RST;
      tool_q <= `RCS_TOOL_LIM_RST;
      irq_mask_q <= 4'h0;
      irq_stat_q <= 4'h0;
      sw_trig_q <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      sw_trig_q <= 1'b0;
      irq <= |(irq_stat_q & irq_mask_q);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_hold_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_hold_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_go)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RCS_RESP_OKAY;
        case (awaddr_q)
          `RCS_ADDR_CTRL: if (wstrb_q[0]) ctrl_q <= wdata_q[7:0];
          `RCS_ADDR_ITER:
          begin
            if (wstrb_q[0]) iter_max_q <= wdata_q[7:0];
            if (wstrb_q[1]) ncap_q <= wdata_q[15:8];
          end
          `RCS_ADDR_DLY: if (wstrb_q[0] && wstrb_q[1]) dly_q <= wdata_q[15:0];
          `RCS_ADDR_GAP: if (wstrb_q[0] && wstrb_q[1]) gap_q <= wdata_q[15:0];
          `RCS_ADDR_CYC: if (wstrb_q[0] && wstrb_q[1]) cyc_q <= wdata_q[15:0];
          `RCS_ADDR_TOOL: if (wstrb_q[0] && wstrb_q[1]) tool_q <= wdata_q[15:0];
          `RCS_ADDR_IRQ: ;
          `RCS_ADDR_MASK: if (wstrb_q[0]) irq_mask_q <= wdata_q[3:0];
          `RCS_ADDR_SWT: if (wstrb_q[0]) sw_trig_q <= wdata_q[0];
          `RCS_ADDR_STAT: ;
          default: s_axi_bresp <= `RCS_RESP_SLVERR;
        endcase
      end
      // Hardware set wins over a write-one clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~((wr_go && awaddr_q == `RCS_ADDR_IRQ && wstrb_q[0]) ?
        wdata_q[3:0] : 4'h0)) | irq_set;
    end
  end
  // AXI4-Lite read path.
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RCS_RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RCS_RESP_OKAY;
      case (s_axi_araddr)
        `RCS_ADDR_CTRL: s_axi_rdata <= {24'h00_0000, ctrl_q};
        `RCS_ADDR_ITER: s_axi_rdata <= {16'h0000, ncap_q, iter_max_q};
        `RCS_ADDR_DLY: s_axi_rdata <= {16'h0000, dly_q};
        `RCS_ADDR_GAP: s_axi_rdata <= {16'h0000, gap_q};
        `RCS_ADDR_CYC: s_axi_rdata <= {16'h0000, cyc_q};
        `RCS_ADDR_TOOL: s_axi_rdata <= {16'h0000, tool_q};
        `RCS_ADDR_STAT: s_axi_rdata <= {16'h0000, iter_q, 1'b0, state_q};
        `RCS_ADDR_IRQ: s_axi_rdata <= {28'h000_0000, irq_stat_q};
        `RCS_ADDR_MASK: s_axi_rdata <= {28'h000_0000, irq_mask_q};
        `RCS_ADDR_SWT: s_axi_rdata <= 32'h0000_0000;
        default:
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RCS_RESP_SLVERR;
        end
      endcase
    end
  end
endmodule // rcs_read_cycle

// File: rcs_read_cycle_chk.sv
// Port checker for the read cycle sequencer.
module rcs_read_cycle_chk
(
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Register bus
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // Capture and decoder
  input wire capture_req,
  input wire capture_done,
  input wire decode_run,
  input wire decode_good,
  input wire decode_abort,
  // Results
  input wire cycle_pass,
  input wire cycle_fail,
  input wire cycle_complete
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write response not on time");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response not on time");
  a_cap_holds: assert property (capture_req && !capture_done
    |=> capture_req || cycle_complete)
    else $error("capture request dropped early");
  a_cap_to_decode: assert property (capture_req && capture_done
    |=> (!capture_req && decode_run) || cycle_complete)
    else $error("decode did not follow capture");
  a_good_stops: assert property (decode_run && decode_good
    |=> !decode_run && !capture_req)
    else $error("work continued after good read");
  a_one_result: assert property (cycle_complete |-> cycle_pass != cycle_fail)
    else $error("complete without a single verdict");
  a_idle_end: assert property (cycle_complete |-> !capture_req && !decode_run)
    else $error("activity after cycle end");
  a_abort_pulse: assert property (decode_abort |=> !decode_abort)
    else $error("abort longer than one cycle");
  a_pass_done: assert property ($rose(cycle_pass) |-> cycle_complete)
    else $error("pass without complete");

  c_pass: cover property (cycle_complete && cycle_pass);
  c_fail: cover property (cycle_complete && cycle_fail);
  c_abort: cover property (decode_abort);
endmodule // rcs_read_cycle_chk

bind rcs_read_cycle rcs_read_cycle_chk u_chk (.*);

// File: test_read_cycle_sequencer.sv
// Self-checking bench for the read cycle sequencer.
`include "rcs_defines.vh"
module test_read_cycle_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic trigger_pin = 1'b0, serial_start = 1'b0, plc_start = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] bresp_seen = 2'b00;
  logic [31:0] s_axi_rdata;
  logic capture_req, capture_done, decode_run, decode_good, decode_fail, decode_abort;
  logic cycle_pass, cycle_fail, cycle_complete, irq;
  logic clr = 1'b0, slow = 1'b0, stall = 1'b0, abort_seen = 1'b0;
  logic [7:0] good_at = 8'h00;
  logic [7:0] cap_cnt;
  int errors = 0, tests_run = 0, cyc = 0;

  rcs_read_cycle DUT (.*);
  rcs_cam_model u_cam (.aclk, .aresetn, .clr, .slow, .stall, .good_at, .cap_cnt,
    .capture_req, .decode_run, .decode_abort, .capture_done, .decode_good, .decode_fail);

  always #5 aclk = ~aclk;

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // The ceiling sits far above the under one thousand cycles the tests need.
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (decode_abort)
      abort_seen <= 1'b1;
    if (cyc == 20000)
    begin
      errors = errors + 1;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axw(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdc(input string what, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(what, d, e);
  endtask

  task automatic kick(input int src);
    @(posedge aclk);
    clr <= 1'b0;
    case (src)
      0: trigger_pin <= 1'b1;
      1: serial_start <= 1'b1;
      default: plc_start <= 1'b1;
    endcase
    repeat (4) @(posedge aclk);
    trigger_pin <= 1'b0;
    serial_start <= 1'b0;
    plc_start <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask

  task automatic finish_cycle(input logic p, input logic f, input logic [31:0] ib);
    int n;
    n = 0;
    while (cycle_complete !== 1'b1 && n < 3000)
    begin
      @(posedge aclk);
      n++;
    end
    chk("complete", cycle_complete, 32'h0000_0001);
    chk("pass", cycle_pass, p);
    chk("fail", cycle_fail, f);
    repeat (2) @(posedge aclk);
    chk("irq", irq, 32'h0000_0001);
    rdc("irq status", `RCS_ADDR_IRQ, ib);
    axw(`RCS_ADDR_IRQ, 32'h0000_000F);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 32'h0000_0000);
  endtask

  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rdc("ctrl", `RCS_ADDR_CTRL, 32'h0000_0005);
    rdc("iter", `RCS_ADDR_ITER, 32'h0000_0101);
    rdc("delay", `RCS_ADDR_DLY, 32'h0000_0000);
    rdc("gap", `RCS_ADDR_GAP, 32'h0000_002D);
    rdc("cycle time", `RCS_ADDR_CYC, 32'h0000_07D0);
    rdc("tool time", `RCS_ADDR_TOOL, 32'h0000_01F4);
    rdc("mask", `RCS_ADDR_MASK, 32'h0000_0000);
    axr(6'h28, d, r);
    chk("unmapped resp", r, `RCS_RESP_SLVERR);
    chk("unmapped data", d, 32'h0000_0000);
    axw(6'h28, 32'h0000_0000);
    chk("unmapped wresp", bresp_seen, `RCS_RESP_SLVERR);
    axw(`RCS_ADDR_CTRL, 32'h0000_0001);
    chk("write resp", bresp_seen, `RCS_RESP_OKAY);
    axw(`RCS_ADDR_GAP, 32'h0000_0000);
    axw(`RCS_ADDR_MASK, 32'h0000_000F);
    $display("registers test done");
  endtask

  task automatic t_good();
    axw(`RCS_ADDR_ITER, 32'h0000_0203);
    good_at <= 8'h01;
    clr <= 1'b1;
    kick(0);
    finish_cycle(1'b1, 1'b0, 32'h0000_0005);
    chk("captures", cap_cnt, 32'h0000_0001);
    repeat (30) @(posedge aclk);
    chk("no restart", cap_cnt, 32'h0000_0001);
    // A software start opens the next cycle; its first capture is the second one counted.
    good_at <= 8'h02;
    axw(`RCS_ADDR_SWT, 32'h0000_0001);
    @(posedge aclk);
    finish_cycle(1'b1, 1'b0, 32'h0000_0005);
    chk("soft captures", cap_cnt, 32'h0000_0002);
    $display("good read test done");
  endtask

  task automatic t_fail();
    good_at <= 8'h00;
    slow <= 1'b1;
    clr <= 1'b1;
    kick(1);
    finish_cycle(1'b0, 1'b1, 32'h0000_0006);
    chk("captures", cap_cnt, 32'h0000_0006);
    slow <= 1'b0;
    $display("failed read test done");
  endtask

  task automatic t_trig();
    axw(`RCS_ADDR_ITER, 32'h0000_0102);
    axw(`RCS_ADDR_CTRL, 32'h0000_0019);
    clr <= 1'b1;
    kick(2);
    repeat (40) @(posedge aclk);
    chk("one pass", cap_cnt, 32'h0000_0001);
    chk("still open", cycle_complete, 32'h0000_0000);
    kick(0);
    finish_cycle(1'b0, 1'b1, 32'h0000_0006);
    chk("two passes", cap_cnt, 32'h0000_0002);
    $display("triggered capture test done");
  endtask

  task automatic t_newtrig();
    int n;
    axw(`RCS_ADDR_ITER, 32'h0000_0101);
    axw(`RCS_ADDR_CTRL, 32'h0000_0003);
    stall <= 1'b1;
    clr <= 1'b1;
    kick(0);
    n = 0;
    while (decode_run !== 1'b1 && n < 100)
    begin
      @(posedge aclk);
      n++;
    end
    chk("decoding", decode_run, 32'h0000_0001);
    rdc("state", `RCS_ADDR_STAT, 32'h0000_0008);
    kick(0);
    finish_cycle(1'b0, 1'b1, 32'h0000_000E);
    chk("abort seen", abort_seen, 32'h0000_0001);
    stall <= 1'b0;
    $display("new trigger test done");
  endtask

  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_good();
    t_fail();
    t_trig();
    t_newtrig();
    close_out();
  end
endmodule // test_read_cycle_sequencer
